//--- design/ftf_host.sv
/*
 host controller driving a 64 x 4 fall-through fifo through its pins.
 assumes the fifo pins are synchronous to clk_in and the chip honours its handshakes.
*/
// Overview of operation
// - push only while space_avail high
// - pop only while output valid high
// - long low ready means full/empty
// - wait 35 ns after clear before push
// - hold clear low at least 10 ns
module ftf_host
	import ftf_pkg::*;
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// user control
	input wire logic clear_req_in,
	input wire logic wr_valid_in,
	input wire ftf_pkg::ftf_nibble_t wr_data_in,
	output logic wr_ready_out,
	input wire logic rd_ready_in,
	output logic rd_valid_out,
	output ftf_pkg::ftf_nibble_t rd_data_out,
	output logic full_out,
	output logic empty_out,
	// fifo chip pins
	output logic clear_n_out,
	output logic push_out,
	output ftf_pkg::ftf_nibble_t wr_nibble_out,
	input wire logic space_avail_in,
	output logic pop_out,
	input wire logic out_valid_in,
	input wire ftf_pkg::ftf_nibble_t rd_nibble_in
);
	import ftf_pkg::*;

	ftf_mode_e mode_ff, nxt_mode;
	logic [CNT_W-1:0] mcnt_ff, nxt_mcnt;
	ftf_wr_e wst_ff, nxt_wst;
	ftf_rd_e rst_ff, nxt_rst;
	logic [CNT_W-1:0] wcnt_ff, nxt_wcnt, rcnt_ff, nxt_rcnt;
	ftf_nibble_t wdat_ff, nxt_wdat, rdat_ff, nxt_rdat;
	logic rvld_ff, nxt_rvld;
	logic [CNT_W-1:0] fcnt_ff, nxt_fcnt, ecnt_ff, nxt_ecnt;
	logic running;

	assign running = (mode_ff == FTF_RUN);

	// clear sequencing
	always_comb
	begin
		nxt_mode = mode_ff;
		nxt_mcnt = mcnt_ff;
		unique case (mode_ff)
			FTF_CLEAR:
			begin
				if (mcnt_ff >= CNT_W'(CLEAR_CYC))
				begin
					nxt_mode = FTF_RECOVER;
					nxt_mcnt = '0;
				end
				else
					nxt_mcnt = mcnt_ff + 1'b1;
			end
			FTF_RECOVER:
			begin
				if (mcnt_ff >= CNT_W'(RECOVERY_CYC))
					nxt_mode = FTF_RUN;
				else
					nxt_mcnt = mcnt_ff + 1'b1;
			end
			FTF_RUN:
			begin
				if (clear_req_in && wst_ff == FTF_W_IDLE && rst_ff == FTF_R_IDLE)
				begin
					nxt_mode = FTF_CLEAR;
					nxt_mcnt = '0;
				end
			end
		endcase
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			mode_ff <= FTF_CLEAR;
			mcnt_ff <= '0;
		end
		else
		begin
			mode_ff <= nxt_mode;
			mcnt_ff <= nxt_mcnt;
		end
	end

	// write side: push pulse of PULSE_CYC high then PULSE_CYC low
	always_comb
	begin
		nxt_wst = wst_ff;
		nxt_wcnt = wcnt_ff;
		nxt_wdat = wdat_ff;
		unique case (wst_ff)
			FTF_W_IDLE:
			begin
				if (running && !clear_req_in && wr_valid_in && space_avail_in)
				begin
					nxt_wst = FTF_W_HIGH;
					nxt_wdat = wr_data_in;
					nxt_wcnt = '0;
				end
			end
			FTF_W_HIGH:
			begin
				if (wcnt_ff + 1'b1 >= CNT_W'(PULSE_CYC))
				begin
					nxt_wst = FTF_W_LOW;
					nxt_wcnt = '0;
				end
				else
					nxt_wcnt = wcnt_ff + 1'b1;
			end
			FTF_W_LOW:
			begin
				if (wcnt_ff + 1'b1 >= CNT_W'(PULSE_CYC))
					nxt_wst = FTF_W_IDLE;
				else
					nxt_wcnt = wcnt_ff + 1'b1;
			end
			default: nxt_wst = FTF_W_IDLE;
		endcase
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			wst_ff <= FTF_W_IDLE;
			wcnt_ff <= '0;
			wdat_ff <= '0;
		end
		else
		begin
			wst_ff <= nxt_wst;
			wcnt_ff <= nxt_wcnt;
			wdat_ff <= nxt_wdat;
		end
	end

	// read side: latch word, then pop pulse
	always_comb
	begin
		nxt_rst = rst_ff;
		nxt_rcnt = rcnt_ff;
		nxt_rdat = rdat_ff;
		nxt_rvld = rvld_ff;
		if (rvld_ff && rd_ready_in)
			nxt_rvld = 1'b0;
		// a clear also drops the word held for the user
		if (mode_ff == FTF_CLEAR)
			nxt_rvld = 1'b0;
		unique case (rst_ff)
			FTF_R_IDLE:
			begin
				if (running && out_valid_in && !nxt_rvld)
				begin
					nxt_rdat = rd_nibble_in;
					nxt_rvld = 1'b1;
					nxt_rst = FTF_R_HIGH;
					nxt_rcnt = '0;
				end
			end
			FTF_R_HIGH:
			begin
				if (rcnt_ff + 1'b1 >= CNT_W'(PULSE_CYC))
				begin
					nxt_rst = FTF_R_LOW;
					nxt_rcnt = '0;
				end
				else
					nxt_rcnt = rcnt_ff + 1'b1;
			end
			FTF_R_LOW:
			begin
				if (rcnt_ff + 1'b1 >= CNT_W'(PULSE_CYC))
					nxt_rst = FTF_R_IDLE;
				else
					nxt_rcnt = rcnt_ff + 1'b1;
			end
			default: nxt_rst = FTF_R_IDLE;
		endcase
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			rst_ff <= FTF_R_IDLE;
			rcnt_ff <= '0;
			rdat_ff <= '0;
			rvld_ff <= 1'b0;
		end
		else
		begin
			rst_ff <= nxt_rst;
			rcnt_ff <= nxt_rcnt;
			rdat_ff <= nxt_rdat;
			rvld_ff <= nxt_rvld;
		end
	end

	// full and empty: ready lines low for the fall-through latency
	always_comb
	begin
		nxt_fcnt = fcnt_ff;
		nxt_ecnt = ecnt_ff;
		if (!running || space_avail_in)
			nxt_fcnt = '0;
		else if (fcnt_ff < CNT_W'(LATENCY_CYC))
			nxt_fcnt = fcnt_ff + 1'b1;
		if (!running || out_valid_in)
			nxt_ecnt = '0;
		else if (ecnt_ff < CNT_W'(LATENCY_CYC))
			nxt_ecnt = ecnt_ff + 1'b1;
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			fcnt_ff <= '0;
			ecnt_ff <= '0;
		end
		else
		begin
			fcnt_ff <= nxt_fcnt;
			ecnt_ff <= nxt_ecnt;
		end
	end

	assign clear_n_out = (mode_ff != FTF_CLEAR);
	assign push_out = (wst_ff == FTF_W_HIGH);
	assign wr_nibble_out = wdat_ff;
	assign pop_out = (rst_ff == FTF_R_HIGH);
	assign wr_ready_out = running && !clear_req_in && (wst_ff == FTF_W_IDLE) && space_avail_in;
	assign rd_valid_out = rvld_ff;
	assign rd_data_out = rdat_ff;
	assign full_out = (fcnt_ff >= CNT_W'(LATENCY_CYC));
	assign empty_out = (ecnt_ff >= CNT_W'(LATENCY_CYC));

	property p_push_needs_space;
		@(posedge clk_in) disable iff (!rst_b_in)
		$rose(push_out) |-> $past(space_avail_in);
	endproperty
	a_push_needs_space: assert property (p_push_needs_space) else $error("push without space");

	property p_pop_needs_valid;
		@(posedge clk_in) disable iff (!rst_b_in)
		$rose(pop_out) |-> $past(out_valid_in);
	endproperty
	a_pop_needs_valid: assert property (p_pop_needs_valid) else $error("pop without valid");

	property p_clear_width;
		@(posedge clk_in) disable iff (!rst_b_in)
		$fell(clear_n_out) |-> !clear_n_out [*2];
	endproperty
	a_clear_width: assert property (p_clear_width) else $error("clear too short");

	property p_recovery;
		@(posedge clk_in) disable iff (!rst_b_in)
		$rose(clear_n_out) |-> !push_out [*2];
	endproperty
	a_recovery: assert property (p_recovery) else $error("push too soon after clear");

	property p_data_stable;
		@(posedge clk_in) disable iff (!rst_b_in)
		$fell(push_out) |-> $stable(wr_nibble_out);
	endproperty
	a_data_stable: assert property (p_data_stable) else $error("write data moved");

	property p_no_push_in_clear;
		@(posedge clk_in) disable iff (!rst_b_in)
		!clear_n_out |-> !push_out && !pop_out;
	endproperty
	a_no_push_in_clear: assert property (p_no_push_in_clear) else $error("strobe in clear");

	property p_capture;
		@(posedge clk_in) disable iff (!rst_b_in)
		$rose(pop_out) |-> rd_data_out == $past(rd_nibble_in);
	endproperty
	a_capture: assert property (p_capture) else $error("read word not captured");

	property p_full_flag;
		@(posedge clk_in) disable iff (!rst_b_in)
		full_out |-> !$past(space_avail_in);
	endproperty
	a_full_flag: assert property (p_full_flag) else $error("full flag wrong");

	c_write: cover property (@(posedge clk_in) $fell(push_out));
	c_read: cover property (@(posedge clk_in) $fell(pop_out));
	c_full: cover property (@(posedge clk_in) $rose(full_out));
	c_empty: cover property (@(posedge clk_in) $rose(empty_out));
endmodule

//--- inc/ftf_pkg.sv
/*
 package for the fifo host controller: pin timing, widths and state names.
 assumes a 40 mhz system clock and a fall-through fifo chip on plain pins.
*/
package ftf_pkg;
	localparam int CLK_PERIOD_NS = 25;
	localparam int NIBBLE_W = 4;
	localparam int FIFO_DEPTH = 64;
	localparam int CLEAR_LOW_NS = 10;
	localparam int RECOVERY_NS = 35;
	localparam int LATENCY_NS = 1000;
	localparam int PULSE_HIGH_NS = 10;
	// least times round up, none below one cycle
	localparam int CLEAR_CYC = (CLEAR_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RECOVERY_CYC = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PULSE_CYC = (PULSE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// full/empty wait is a least time, so round up
	localparam int LATENCY_CYC = (LATENCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 8;
	typedef logic [NIBBLE_W-1:0] ftf_nibble_t;
	typedef enum logic [1:0] {FTF_CLEAR, FTF_RECOVER, FTF_RUN} ftf_mode_e;
	typedef enum logic [1:0] {FTF_W_IDLE, FTF_W_HIGH, FTF_W_LOW} ftf_wr_e;
	typedef enum logic [1:0] {FTF_R_IDLE, FTF_R_HIGH, FTF_R_LOW} ftf_rd_e;
endpackage

//--- tb/ftf_chip_model.sv
/*
 behavioural fall-through fifo chip on the far side of the host.
 assumes pins change on clk_in edges; lag_in sets fall-through cycles.
*/
module ftf_chip_model
	import ftf_pkg::*;
(
	input wire logic clk_in,
	input wire logic clear_n_in,
	input wire logic push_in,
	input wire logic pop_in,
	input wire ftf_pkg::ftf_nibble_t wr_nibble_in,
	input wire logic [7:0] lag_in,
	output logic space_avail_out = 1'b0,
	output logic out_valid_out = 1'b0,
	output ftf_pkg::ftf_nibble_t rd_nibble_out = 4'h0
);
	timeunit 1ns;
	timeprecision 1ps;
	ftf_nibble_t q[$];
	ftf_nibble_t held;
	logic push_ff = 1'b0;
	logic pop_ff = 1'b0;
	int has_out = 0;
	int wait_cnt = 0;
	always @(posedge clk_in)
	begin
		if (!clear_n_in)
		begin
			q.delete();
			has_out = 0;
			wait_cnt = 0;
			out_valid_out <= 1'b0;
			space_avail_out <= 1'b1;
		end
		else
		begin
			if (push_in && !push_ff)
				held = wr_nibble_in;
			if (!push_in && push_ff)
				q.push_back(held);
			if (!pop_in && pop_ff)
				has_out = 0;
			if (has_out == 0 && q.size() > 0)
			begin
				if (wait_cnt >= lag_in)
				begin
					rd_nibble_out <= q.pop_front();
					has_out = 1;
					wait_cnt = 0;
				end
				else
					wait_cnt++;
			end
			space_avail_out <= !push_in && (q.size() + has_out < FIFO_DEPTH);
			out_valid_out <= has_out == 1 && !pop_in;
		end
		push_ff <= push_in;
		pop_ff <= pop_in;
	end
endmodule

//--- tb/tb_top.sv
/*
 self-checking bench for the fifo host controller.
 assumes the chip model on the pins; inputs change at falling edges.
*/
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import ftf_pkg::*;
	logic clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic clear_req_in = 1'b0;
	logic wr_valid_in = 1'b0;
	logic rd_ready_in = 1'b0;
	ftf_nibble_t wr_data_in = 4'h0;
	logic wr_ready_out, rd_valid_out, full_out, empty_out, clear_n_out, push_out, pop_out;
	logic space_avail_in, out_valid_in;
	ftf_nibble_t rd_data_out, wr_nibble_out, rd_nibble_in;
	logic [7:0] lag = 8'h00;
	int num_errors = 0;
	int checks_done = 0;
	typedef struct {ftf_nibble_t d; logic [7:0] lag; ftf_nibble_t exp;} ftf_row_s;
	ftf_row_s rows[4] = '{'{4'h0, 8'h00, 4'h0}, '{4'hf, 8'h05, 4'hf}, '{4'ha, 8'h27, 4'ha},
		'{4'h5, 8'h01, 4'h5}};
	ftf_host i_ftf_host (.clk_in, .rst_b_in, .clear_req_in, .wr_valid_in, .wr_data_in,
		.wr_ready_out, .rd_ready_in, .rd_valid_out, .rd_data_out, .full_out, .empty_out,
		.clear_n_out, .push_out, .wr_nibble_out, .space_avail_in, .pop_out, .out_valid_in,
		.rd_nibble_in);
	ftf_chip_model i_ftf_chip_model (.clk_in(clk_in), .clear_n_in(clear_n_out),
		.push_in(push_out), .pop_in(pop_out), .wr_nibble_in(wr_nibble_out), .lag_in(lag),
		.space_avail_out(space_avail_in), .out_valid_out(out_valid_in),
		.rd_nibble_out(rd_nibble_in));
	initial
	begin
		forever #12.5 clk_in = ~clk_in;
	end
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk_bit(string n, logic e, logic g);
		checks_done++;
		if (g !== e)
		begin
			num_errors++;
			$display("mismatch %s exp %b got %b", n, e, g);
		end
	endtask
	task automatic chk_nib(string n, ftf_nibble_t e, ftf_nibble_t g);
		checks_done++;
		if (g !== e)
		begin
			num_errors++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wait_hi(ref logic s);
		int n;
		n = 0;
		while (s !== 1'b1)
		begin
			@(negedge clk_in);
			n++;
			if (n > 3000)
			begin
				num_errors++;
				$display("mismatch timeout exp 1 got 0");
				tally_and_finish();
			end
		end
	endtask
	task automatic wr(ftf_nibble_t d);
		wait_hi(wr_ready_out);
		wr_valid_in = 1'b1;
		wr_data_in = d;
		@(negedge clk_in);
		wr_valid_in = 1'b0;
	endtask
	task automatic rd(ftf_nibble_t e);
		wait_hi(rd_valid_out);
		chk_nib("rd_data", e, rd_data_out);
		rd_ready_in = 1'b1;
		@(negedge clk_in);
		rd_ready_in = 1'b0;
	endtask
	initial
	begin
		repeat (10) @(negedge clk_in);
		chk_bit("clear_n", 1'b0, clear_n_out);
		chk_bit("push", 1'b0, push_out);
		rst_b_in = 1'b1;
		foreach (rows[i])
		begin
			lag = rows[i].lag;
			wr(rows[i].d);
			rd(rows[i].exp);
		end
		lag = 8'h00;
		for (int i = 0; i <= FIFO_DEPTH; i++)
			wr(4'(i));
		repeat (LATENCY_CYC + 5) @(negedge clk_in);
		chk_bit("full", 1'b1, full_out);
		chk_bit("wr_ready", 1'b0, wr_ready_out);
		for (int i = 0; i <= FIFO_DEPTH; i++)
			rd(4'(i));
		repeat (LATENCY_CYC + 5) @(negedge clk_in);
		chk_bit("empty", 1'b1, empty_out);
		chk_bit("rd_valid", 1'b0, rd_valid_out);
		chk_nib("rd_nibble", 4'(FIFO_DEPTH), rd_nibble_in);
		chk_nib("rd_data_hold", 4'(FIFO_DEPTH), rd_data_out);
		for (int i = 1; i < 4; i++)
			wr(4'(i));
		repeat (8) @(negedge clk_in);
		clear_req_in = 1'b1;
		repeat (4) @(negedge clk_in);
		clear_req_in = 1'b0;
		repeat (10) @(negedge clk_in);
		chk_bit("out_valid", 1'b0, out_valid_in);
		chk_bit("space_avail", 1'b1, space_avail_in);
		chk_bit("rd_valid_clr", 1'b0, rd_valid_out);
		// reset in mid-run with a word in flight
		wr(4'h9);
		@(negedge clk_in);
		rst_b_in = 1'b0;
		repeat (3) @(negedge clk_in);
		chk_bit("clear_n_rst", 1'b0, clear_n_out);
		chk_bit("rd_valid_rst", 1'b0, rd_valid_out);
		rst_b_in = 1'b1;
		wr(4'h6);
		rd(4'h6);
		tally_and_finish();
	end
endmodule
